// ==== hdl/sgp_port.sv ====
// sgp_port: nine-pin gpio block with apb register access and alternate signals.
// assumes an apb master on pclk and pad cells that resolve o/oe per pin.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps

module sgp_port
#(
  parameter int unsigned PINS = 9
)
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [PINS-1:0]      pin_in,
  output logic      [PINS-1:0]      pin_out,
  output logic      [PINS-1:0]      pin_oe,
  input  wire sgp_pkg::sgp_core_type core_status,
  output logic                      expander_interrupt_in
);

  // every control field is nine bits wide, so no other pin count works
  if (PINS != sgp_pkg::PIN_COUNT)
  begin : g_pin_check
    $error("sgp_port supports exactly nine pins");
  end

  typedef struct packed {
    logic [8:0]  pin_function_select;
    logic [8:0]  pin_direction_select;
    logic [8:0]  pin_data_value;
    logic [8:0]  alternate_signal_select;
    logic [8:0]  sampled;
    logic [7:0]  gap_cnt;
    logic [8:0]  pad_o;
    logic [8:0]  pad_oe;
    logic        exp_int;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } sgp_state_type;

  sgp_state_type st_reg;
  sgp_state_type st_next;

  logic [8:0] sync_q;
  logic       setup;
  logic       access;
  logic [31:0] wmask;
  logic [8:0] is_alt;
  logic [8:0] is_out;
  logic [8:0] alt_oe;
  logic [8:0] alt_o;
  logic       mapped;
  logic [31:0] rd_word;

  // pins idle high so active-low inputs read inactive before sampling
  for (genvar i = 0; i < PINS; i++)
  begin : g_sync
    sgp_sync #(
      .RESET_VALUE (1'b1)
    ) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .ce    (clk_en),
      .d     (pin_in[i]),
      .q     (sync_q[i])
    );
  end

  assign setup  = psel && !penable;
  assign access = psel && penable && st_reg.ready;
  assign wmask  = {{8{pstrb[3]}}, {8{pstrb[2]}},
                   {8{pstrb[1]}}, {8{pstrb[0]}}};

  // alternate signal map; unlisted options leave the pin undriven as input
  always_comb
  begin
    alt_oe = '0;
    alt_o  = '1;
    if (st_reg.alternate_signal_select[sgp_pkg::LINK_UP_PIN])
    begin
      alt_oe[sgp_pkg::LINK_UP_PIN] = 1'b1;
      alt_o[sgp_pkg::LINK_UP_PIN]  = core_status.port0_link_up_n;
    end
    alt_oe[sgp_pkg::EVENT_PIN] = 1'b1;
    alt_o[sgp_pkg::EVENT_PIN]  =
      st_reg.alternate_signal_select[sgp_pkg::EVENT_PIN] ?
      core_status.port0_link_active_n :
      core_status.hotplug_event_signal_n;
  end

  assign is_alt = st_reg.pin_function_select;
  assign is_out = ~st_reg.pin_function_select &
                  st_reg.pin_direction_select;

  always_comb
  begin
    mapped  = 1'b1;
    rd_word = '0;
    case (paddr)
      sgp_pkg::FUNC_OFFSET:
        rd_word[8:0] = st_reg.pin_function_select;
      sgp_pkg::DIR_OFFSET:
        rd_word[8:0] = st_reg.pin_direction_select;
      sgp_pkg::DATA_OFFSET:
        rd_word[8:0] = st_reg.sampled;
      sgp_pkg::ALTSEL_OFFSET:
        rd_word[8:0] = st_reg.alternate_signal_select;
      sgp_pkg::STATUS_OFFSET:
        rd_word[8:0] = st_reg.pad_oe;
      sgp_pkg::CORE_OFFSET:
        rd_word[3:0] = {st_reg.exp_int, core_status};
      default:
        mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    st_next       = st_reg;
    st_next.ready = 1'b0;
    // slow sampler: the synchronised level is taken once per gap
    if (st_reg.gap_cnt == 8'(sgp_pkg::SAMPLE_CYCLES - 1))
    begin
      st_next.gap_cnt = '0;
      st_next.sampled = sync_q;
    end
    else
    begin
      st_next.gap_cnt = st_reg.gap_cnt + 8'h01;
    end
    for (int i = 0; i < 9; i++)
    begin
      if (!is_out[i] && !is_alt[i])
      begin
        st_next.pin_data_value[i] = st_reg.sampled[i];
      end
    end
    // pin 8 alternate 0 is the only alternate input
    if (is_alt[sgp_pkg::EXP_INT_PIN] &&
        !st_reg.alternate_signal_select[sgp_pkg::EXP_INT_PIN])
    begin
      st_next.exp_int = st_reg.sampled[sgp_pkg::EXP_INT_PIN];
    end
    else
    begin
      st_next.exp_int = 1'b1;
    end
    // event only leaves on pin 5 when that pin is in alternate mode
    st_next.pad_oe = (is_out | (is_alt & alt_oe));
    st_next.pad_o  = (is_out & st_reg.pin_data_value) |
                     (is_alt & alt_o);
    if (setup)
    begin
      st_next.ready  = 1'b1;
      st_next.slverr = !mapped;
      st_next.rdata  = pwrite ? 32'h0000_0000 : rd_word;
    end
    if (access && pwrite && mapped)
    begin
      case (paddr)
        sgp_pkg::FUNC_OFFSET:
          st_next.pin_function_select =
            (st_reg.pin_function_select & ~wmask[8:0]) |
            (pwdata[8:0] & wmask[8:0]);
        sgp_pkg::DIR_OFFSET:
          st_next.pin_direction_select =
            (st_reg.pin_direction_select & ~wmask[8:0]) |
            (pwdata[8:0] & wmask[8:0]);
        sgp_pkg::DATA_OFFSET:
          for (int i = 0; i < 9; i++)
          begin
            if (wmask[i] && is_out[i])
            begin
              st_next.pin_data_value[i] = pwdata[i];
            end
          end
        sgp_pkg::ALTSEL_OFFSET:
          st_next.alternate_signal_select =
            (st_reg.alternate_signal_select & ~wmask[8:0]) |
            (pwdata[8:0] & wmask[8:0]);
        default:
          st_next.slverr = st_reg.slverr;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg                         <= '0;
      st_reg.pin_function_select     <= sgp_pkg::FUNC_RESET;
      st_reg.pin_direction_select    <= sgp_pkg::DIR_RESET;
      st_reg.alternate_signal_select <= sgp_pkg::ALTSEL_RESET;
      st_reg.pin_data_value          <= sgp_pkg::PIN_IDLE_RESET;
      st_reg.sampled                 <= sgp_pkg::PIN_IDLE_RESET;
      st_reg.pad_o                   <= sgp_pkg::PIN_IDLE_RESET;
      st_reg.exp_int                 <= 1'b1;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  assign prdata                = st_reg.rdata;
  assign pready                = st_reg.ready;
  assign pslverr               = st_reg.slverr;
  assign pin_out               = st_reg.pad_o;
  assign pin_oe                = st_reg.pad_oe;
  assign expander_interrupt_in = st_reg.exp_int;

  property p_reset_input;
    @(posedge pclk) $rose(presetn) |-> pin_oe == 9'h000;
  endproperty
  a_reset_input: assert property (p_reset_input)
    else $error("pin driven right after reset");

  property p_out_drive;
    @(posedge pclk) disable iff (!presetn)
    clk_en |=>
      ((pin_oe & $past(is_out)) == $past(is_out)) &&
      (((pin_out ^ $past(st_reg.pin_data_value)) & $past(is_out)) ==
       9'h000);
  endproperty
  a_out_drive: assert property (p_out_drive)
    else $error("output pin does not follow data bit");

  property p_input_undriven;
    @(posedge pclk) disable iff (!presetn)
    clk_en && !is_out[3] && !is_alt[3] |=> (!clk_en || !pin_oe[3]);
  endproperty
  a_input_undriven: assert property (p_input_undriven)
    else $error("general input pin is driven");

  property p_event_gate;
    @(posedge pclk) disable iff (!presetn)
    clk_en && !is_alt[5] && !is_out[5] |=> (!clk_en || !pin_oe[5]);
  endproperty
  a_event_gate: assert property (p_event_gate)
    else $error("event pin driven outside alternate mode");

  property p_alt_event;
    @(posedge pclk) disable iff (!presetn)
    clk_en && is_alt[5] && !st_reg.alternate_signal_select[5] |=>
      (!clk_en || (pin_oe[5] &&
       pin_out[5] == $past(core_status.hotplug_event_signal_n)));
  endproperty
  a_alt_event: assert property (p_alt_event)
    else $error("pin 5 option 0 does not carry the event");

  property p_linkup;
    @(posedge pclk) disable iff (!presetn)
    clk_en && is_alt[4] && st_reg.alternate_signal_select[4] |=>
      (!clk_en || (pin_oe[4] &&
       pin_out[4] == $past(core_status.port0_link_up_n)));
  endproperty
  a_linkup: assert property (p_linkup)
    else $error("pin 4 option 1 does not carry link up");

  property p_exp_idle;
    @(posedge pclk) disable iff (!presetn)
    clk_en && !is_alt[8] |=> (!clk_en || expander_interrupt_in);
  endproperty
  a_exp_idle: assert property (p_exp_idle)
    else $error("expander interrupt active while not enabled");

  property p_exp_in;
    @(posedge pclk) disable iff (!presetn)
    clk_en && is_alt[8] && !st_reg.alternate_signal_select[8] |=>
      (!clk_en || !pin_oe[8]);
  endproperty
  a_exp_in: assert property (p_exp_in)
    else $error("alternate input pin is driven");

  property p_gap;
    @(posedge pclk) disable iff (!presetn)
    st_reg.gap_cnt != 8'h00 |-> $stable(st_reg.sampled);
  endproperty
  a_gap: assert property (p_gap)
    else $error("pins sampled faster than the gap");

  property p_reset_config;
    @(posedge pclk) $rose(presetn) |->
      st_reg.pin_function_select == sgp_pkg::FUNC_RESET &&
      st_reg.pin_direction_select == sgp_pkg::DIR_RESET &&
      expander_interrupt_in;
  endproperty
  a_reset_config: assert property (p_reset_config)
    else $error("pins not configured as inputs after reset");

  property p_sample_take;
    @(posedge pclk) disable iff (!presetn)
    clk_en && st_reg.gap_cnt == 8'(sgp_pkg::SAMPLE_CYCLES - 1) |=>
      st_reg.sampled == $past(sync_q);
  endproperty
  a_sample_take: assert property (p_sample_take)
    else $error("synchronised pins not taken at the gap end");

  property p_input_capture;
    @(posedge pclk) disable iff (!presetn)
    clk_en |=>
      ((st_reg.pin_data_value ^ $past(st_reg.sampled)) &
       $past(~is_out & ~is_alt)) == 9'h000;
  endproperty
  a_input_capture: assert property (p_input_capture)
    else $error("input pin level not captured into its data bit");

  property p_data_read;
    @(posedge pclk) disable iff (!presetn)
    clk_en && psel && !penable && !pwrite &&
      paddr == sgp_pkg::DATA_OFFSET |=>
      prdata == {23'h000000, $past(st_reg.sampled)};
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("data read does not return the sampled pins");

  property p_alt_active;
    @(posedge pclk) disable iff (!presetn)
    clk_en && is_alt[5] && st_reg.alternate_signal_select[5] |=>
      (!clk_en || (pin_oe[5] &&
       pin_out[5] == $past(core_status.port0_link_active_n)));
  endproperty
  a_alt_active: assert property (p_alt_active)
    else $error("pin 5 option 1 does not carry link active");

  property p_exp_follow;
    @(posedge pclk) disable iff (!presetn)
    clk_en && is_alt[8] && !st_reg.alternate_signal_select[8] |=>
      expander_interrupt_in == $past(st_reg.sampled[8]);
  endproperty
  a_exp_follow: assert property (p_exp_follow)
    else $error("pin 8 option 0 does not feed the expander interrupt");

endmodule : sgp_port

// ==== hdl/sgp_sync.sv ====
// sgp_sync: three-flop synchroniser with agreement filter for one pin.
// assumes d is asynchronous to clk; out changes only when stages 2 and 3 agree.
`timescale 1ns/1ps
module sgp_sync
#(
  parameter logic RESET_VALUE = 1'b1
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sgp_sync_state_type;

  sgp_sync_state_type st_reg;
  sgp_sync_state_type st_next;

  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3)
    begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= {4{RESET_VALUE}};
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.q;

endmodule : sgp_sync

// ==== include/sgp_pkg.sv ====
// sgp_pkg: constants, register map and carrier types for the switch gpio port.
// assumes a 200 mhz apb clock and nine gpio pins.
package sgp_pkg;

  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned SAMPLE_GAP_NS   = 128;
  localparam int unsigned SAMPLE_CYCLES   =
    (SAMPLE_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PIN_COUNT       = 9;

  localparam logic [11:0] FUNC_OFFSET     = 12'h000;
  localparam logic [11:0] DIR_OFFSET      = 12'h004;
  localparam logic [11:0] DATA_OFFSET     = 12'h008;
  localparam logic [11:0] ALTSEL_OFFSET   = 12'h00c;
  localparam logic [11:0] STATUS_OFFSET   = 12'h010;
  localparam logic [11:0] CORE_OFFSET     = 12'h014;

  localparam int unsigned LINK_UP_PIN     = 4;
  localparam int unsigned EVENT_PIN       = 5;
  localparam int unsigned EXP_INT_PIN     = 8;

  localparam logic [8:0]  FUNC_RESET      = 9'h000;
  localparam logic [8:0]  DIR_RESET       = 9'h000;
  localparam logic [8:0]  ALTSEL_RESET    = 9'h000;
  localparam logic [8:0]  PIN_IDLE_RESET  = 9'h1ff;

  // core-side status, all active low
  typedef struct packed {
    logic hotplug_event_signal_n;
    logic port0_link_up_n;
    logic port0_link_active_n;
  } sgp_core_type;

  typedef struct packed {
    logic [8:0] o;
    logic [8:0] oe;
  } sgp_pad_type;

endpackage : sgp_pkg

// ==== testbench/sgp_board.sv ====
// sgp_board: board-side model of the nine gpio pads.
// assumes the device drive wins wherever its output enable is high.
`timescale 1ns/1ps
module sgp_board
(
  input  wire logic [8:0] pin_out,
  input  wire logic [8:0] pin_oe,
  input  wire logic [8:0] drive,
  output logic      [8:0] pin_in
);
  // released pads show the board level, never a stale device level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule : sgp_board

// ==== testbench/sgp_port_tb.sv ====
// sgp_port_tb: self-checking bench for the switch gpio port.
// assumes an apb master on pclk and the board model on the pads.
`timescale 1ns/1ps
module sgp_port_tb;
  logic                 pclk        = 1'b0;
  logic                 presetn     = 1'b0;
  logic                 clk_en      = 1'b1;
  logic                 psel        = 1'b0;
  logic                 penable     = 1'b0;
  logic                 pwrite      = 1'b0;
  logic [11:0]          paddr       = 12'h000;
  logic [31:0]          pwdata      = 32'h0;
  logic [3:0]           pstrb       = 4'hf;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [8:0]           pin_in;
  logic [8:0]           pin_out;
  logic [8:0]           pin_oe;
  logic [8:0]           drive       = 9'h1ff;
  sgp_pkg::sgp_core_type core_status = 3'b111;
  logic                 expander_interrupt_in;
  logic [31:0]          rd_data;
  logic                 rd_err;
  int                   fails       = 0;
  int                   n_compared  = 0;
  int                   cycles      = 0;

  always #2.5 pclk = ~pclk;

  sgp_port u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .core_status(core_status),
    .expander_interrupt_in(expander_interrupt_in));

  sgp_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .drive(drive),
    .pin_in(pin_in));

  task complete_run;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // the run needs under two thousand cycles
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails = fails + 1;
      $display("Error at %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic reg_is(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd_data, exp);
  endtask : reg_is

  // input sync plus two 26-cycle sample slots fits well inside 90
  task settle;
    repeat (90) @(posedge pclk);
  endtask : settle

  task t_reset;
    chk({23'h0, pin_oe}, 32'h0);
    chk({31'h0, expander_interrupt_in}, 32'h1);
    reg_is(sgp_pkg::FUNC_OFFSET, 32'h0);
    reg_is(sgp_pkg::DIR_OFFSET, 32'h0);
    reg_is(sgp_pkg::ALTSEL_OFFSET, 32'h0);
    xfer(1'b0, 12'h018, 32'h0);
    chk({rd_data[31:1], rd_err}, 32'h1);
  endtask : t_reset

  task t_input;
    drive <= 9'h0a5;
    settle();
    reg_is(sgp_pkg::DATA_OFFSET, 32'h0a5);
    drive <= 9'h15a;
    settle();
    reg_is(sgp_pkg::DATA_OFFSET, 32'h15a);
  endtask : t_input

  task t_output;
    drive <= 9'h1ff;
    xfer(1'b1, sgp_pkg::DIR_OFFSET, 32'h0f0);
    xfer(1'b1, sgp_pkg::DATA_OFFSET, 32'h0a0);
    repeat (2) @(posedge pclk);
    chk({23'h0, pin_oe}, 32'h0f0);
    chk({23'h0, pin_out & pin_oe}, 32'h0a0);
    reg_is(sgp_pkg::STATUS_OFFSET, 32'h0f0);
    settle();
    reg_is(sgp_pkg::DATA_OFFSET, 32'h1af);
    xfer(1'b1, sgp_pkg::DIR_OFFSET, 32'h100);
  endtask : t_output

  // pin 8 keeps direction 1 to show the function bit overrides it
  task t_alt;
    drive       <= 9'h0ff;
    core_status <= 3'b010;
    xfer(1'b1, sgp_pkg::ALTSEL_OFFSET, 32'h010);
    xfer(1'b1, sgp_pkg::FUNC_OFFSET, 32'h130);
    settle();
    chk({23'h0, pin_oe}, 32'h030);
    chk({23'h0, pin_out & 9'h030}, 32'h010);
    chk({31'h0, expander_interrupt_in}, 32'h0);
    reg_is(sgp_pkg::CORE_OFFSET, 32'h2);
    drive       <= 9'h1ff;
    core_status <= 3'b101;
    xfer(1'b1, sgp_pkg::ALTSEL_OFFSET, 32'h030);
    settle();
    chk({23'h0, pin_out & 9'h030}, 32'h020);
    chk({31'h0, expander_interrupt_in}, 32'h1);
    reg_is(sgp_pkg::DATA_OFFSET, 32'h1ef);
  endtask : t_alt

  task t_inactive;
    xfer(1'b1, sgp_pkg::DIR_OFFSET, 32'h0);
    xfer(1'b1, sgp_pkg::FUNC_OFFSET, 32'h0);
    drive       <= 9'h000;
    core_status <= 3'b000;
    settle();
    chk({23'h0, pin_oe}, 32'h0);
    chk({31'h0, expander_interrupt_in}, 32'h1);
    reg_is(sgp_pkg::DATA_OFFSET, 32'h0);
  endtask : t_inactive

  // frozen synchronisers must keep a pad change out of the data read
  task t_freeze;
    clk_en <= 1'b0;
    drive  <= 9'h0c3;
    repeat (60) @(posedge pclk);
    clk_en <= 1'b1;
    reg_is(sgp_pkg::DATA_OFFSET, 32'h0);
    settle();
    reg_is(sgp_pkg::DATA_OFFSET, 32'h0c3);
  endtask : t_freeze

  task t_rereset;
    xfer(1'b1, sgp_pkg::DIR_OFFSET, 32'h00f);
    repeat (2) @(posedge pclk);
    chk({23'h0, pin_oe}, 32'h00f);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({23'h0, pin_oe}, 32'h0);
    presetn <= 1'b1;
    reg_is(sgp_pkg::DIR_OFFSET, 32'h0);
  endtask : t_rereset

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_input();
    t_output();
    t_alt();
    t_inactive();
    t_freeze();
    t_rereset();
    complete_run();
  end
endmodule : sgp_port_tb
